// File: ccsr_pkg.sv
// constants, format-word decoding and types for the context save/restore unit
package ccsr_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 32;
  localparam int CNT_W = 6;
  localparam int FIFO_DEPTH = 16;

  // format word layout: code in the upper byte, byte length in the lower
  localparam int FMT_CODE_HI = 15;
  localparam int FMT_CODE_LO = 8;
  localparam int FMT_LEN_HI = 7;
  localparam int FMT_LEN_LO = 0;
  localparam int LEN_WORD_LO = 2;

  // operation word fields
  localparam int COPROCESSOR_ID_FIELD_HI = 11;
  localparam int COPROCESSOR_ID_FIELD_LO = 9;
  localparam int EAMODE_HI = 5;
  localparam int EAMODE_LO = 0;

  // format word sits in the upper half of the frame's first long word,
  // the filler half below it
  localparam int MEM_FMT_HI = 31;
  localparam int MEM_FMT_LO = 16;
  localparam logic [15:0] FILLER_WORD = 16'h0000;

  localparam logic [7:0] CODE_EMPTY = 8'h00;
  localparam logic [7:0] CODE_NOTRDY = 8'h01;
  localparam logic [7:0] CODE_INVALID = 8'h02;
  localparam logic [7:0] CODE_VALID_MIN = 8'h10;

  // interface register selects
  localparam logic [2:0] IR_SEL_SAVE = 3'h0;
  localparam logic [2:0] IR_SEL_RESTORE = 3'h1;
  localparam logic [2:0] IR_SEL_OPERAND = 3'h2;
  localparam logic [2:0] IR_SEL_CONTROL = 3'h3;
  localparam logic [15:0] CTRL_ABORT_MASK = 16'h0001;

  localparam logic [ADDR_W-1:0] MEM_STEP = 32'h0000_0004;
  localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;

  typedef enum logic [1:0] {
    FC_EMPTY = 2'b00,
    FC_NOTRDY = 2'b01,
    FC_INVALID = 2'b10,
    FC_VALID = 2'b11
  } ccsr_fclass_t;

  // reserved codes fall through to invalid
  function automatic ccsr_fclass_t fmt_class(input logic [15:0] fw);
    logic [7:0] c;
    c = fw[FMT_CODE_HI:FMT_CODE_LO];
    if (c == CODE_EMPTY) begin
      return FC_EMPTY;
    end else if (c == CODE_NOTRDY) begin
      return FC_NOTRDY;
    end else if (c >= CODE_VALID_MIN) begin
      return FC_VALID;
    end else begin
      return FC_INVALID;
    end
  endfunction

  function automatic logic len_ok(input logic [15:0] fw);
    return fw[LEN_WORD_LO-1:FMT_LEN_LO] == 2'h0;
  endfunction

  function automatic logic [CNT_W-1:0] len_words(input logic [15:0] fw);
    return fw[FMT_LEN_HI:LEN_WORD_LO];
  endfunction

endpackage

// File: ccsr_fifo.sv
// synchronous valid/ready fifo for state-frame long words
`timescale 1ns/1ps
`default_nettype none
module ccsr_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW:0] wr_q;
  logic [PW:0] rd_q;
  logic push;
  logic pop;

  assign o_in_ready = !((wr_q[PW] != rd_q[PW]) &&
                        (wr_q[PW-1:0] == rd_q[PW-1:0]));
  assign o_out_valid = (wr_q != rd_q);
  assign o_out_data = mem_q[rd_q[PW-1:0]];
  assign push = i_in_valid && o_in_ready;
  assign pop = i_out_ready && o_out_valid;

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_q[wr_q[PW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + (PW+1)'(1);
      end
      if (pop) begin
        rd_q <= rd_q + (PW+1)'(1);
      end
    end
  end

endmodule
`default_nettype wire

// File: ccsr_ctx.sv
// context save/restore sequencer of the main processor
`timescale 1ns/1ps
`default_nettype none
module ccsr_ctx
  import ccsr_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // instruction start
  input wire logic i_start,
  input wire logic i_is_save,
  input wire logic i_supervisor,
  input wire logic [15:0] i_opword,
  input wire logic [ADDR_W-1:0] i_ea,
  // status
  output logic o_busy,
  output logic o_done,
  output logic o_fmt_err,
  output logic o_priv_viol,
  output logic [15:0] o_last_format,
  output logic [2:0] o_ea_mode_hi,
  output logic [2:0] o_ea_reg,
  // interrupt service
  output logic o_int_svc_req,
  input wire logic i_int_svc_done,
  // interface register port
  output logic o_ir_req,
  output logic o_ir_we,
  output logic [2:0] o_ir_sel,
  output logic [2:0] o_ir_coprocessor_id_field,
  output logic [DATA_W-1:0] o_ir_wdata,
  input wire logic i_ir_ack,
  input wire logic [DATA_W-1:0] i_ir_rdata,
  // memory port
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [ADDR_W-1:0] o_mem_addr,
  output logic [DATA_W-1:0] o_mem_wdata,
  input wire logic i_mem_ack,
  input wire logic [DATA_W-1:0] i_mem_rdata
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_SV_RD = 4'b0001,
    ST_SV_INT = 4'b0010,
    ST_SV_FMT = 4'b0011,
    ST_RS_MRD = 4'b0100,
    ST_RS_WR = 4'b0101,
    ST_RS_RD = 4'b0110,
    ST_XFER = 4'b0111,
    ST_ABORT = 4'b1000
  } ccsr_state_t;

  ccsr_state_t state_q;
  logic save_q;
  logic [ADDR_W-1:0] ea_q;
  logic [ADDR_W-1:0] xaddr_q;
  logic [15:0] fmt_q;
  logic [CNT_W-1:0] src_left_q;
  logic [CNT_W-1:0] snk_left_q;
  logic [5:0] eamode_q;
  logic done_q;
  logic ferr_q;
  logic priv_q;
  logic int_req_q;
  logic ir_req_q;
  logic ir_we_q;
  logic [2:0] ir_sel_q;
  logic [2:0] coprocessor_id_field_q;
  logic [DATA_W-1:0] ir_wdata_q;
  logic mem_req_q;
  logic mem_we_q;
  logic [ADDR_W-1:0] mem_addr_q;
  logic [DATA_W-1:0] mem_wdata_q;

  logic xfer;
  logic f_in_valid;
  logic f_in_ready;
  logic [DATA_W-1:0] f_in_data;
  logic f_out_valid;
  logic f_out_ready;
  logic [DATA_W-1:0] f_out_data;
  logic [15:0] ir_fw;
  logic [15:0] mem_fw;

  assign ir_fw = i_ir_rdata[15:0];
  assign mem_fw = i_mem_rdata[MEM_FMT_HI:MEM_FMT_LO];
  assign xfer = (state_q == ST_XFER);

  // the fifo decouples the two ports so one slow side does not stall the other
  assign f_in_valid = xfer && (save_q ? (ir_req_q && i_ir_ack)
                                      : (mem_req_q && i_mem_ack));
  assign f_in_data = save_q ? i_ir_rdata : i_mem_rdata;
  assign f_out_ready = xfer && (save_q ? !mem_req_q : !ir_req_q);

  ccsr_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_in_valid(f_in_valid),
    .i_in_data(f_in_data),
    .o_in_ready(f_in_ready),
    .o_out_valid(f_out_valid),
    .o_out_data(f_out_data),
    .i_out_ready(f_out_ready)
  );

  assign o_busy = (state_q != ST_IDLE);
  assign o_done = done_q;
  assign o_fmt_err = ferr_q;
  assign o_priv_viol = priv_q;
  assign o_last_format = fmt_q;
  assign o_ea_mode_hi = eamode_q[5:3];
  assign o_ea_reg = eamode_q[2:0];
  assign o_int_svc_req = int_req_q;
  assign o_ir_req = ir_req_q;
  assign o_ir_we = ir_we_q;
  assign o_ir_sel = ir_sel_q;
  assign o_ir_coprocessor_id_field = coprocessor_id_field_q;
  assign o_ir_wdata = ir_wdata_q;
  assign o_mem_req = mem_req_q;
  assign o_mem_we = mem_we_q;
  assign o_mem_addr = mem_addr_q;
  assign o_mem_wdata = mem_wdata_q;

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      state_q <= ST_IDLE;
      save_q <= 1'b0;
      ea_q <= '0;
      xaddr_q <= '0;
      fmt_q <= '0;
      src_left_q <= CNT_ZERO;
      snk_left_q <= CNT_ZERO;
      eamode_q <= '0;
      coprocessor_id_field_q <= '0;
      done_q <= 1'b0;
      ferr_q <= 1'b0;
      priv_q <= 1'b0;
      int_req_q <= 1'b0;
      ir_req_q <= 1'b0;
      ir_we_q <= 1'b0;
      ir_sel_q <= IR_SEL_SAVE;
      ir_wdata_q <= '0;
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_addr_q <= '0;
      mem_wdata_q <= '0;
    end else begin
      done_q <= 1'b0;
      ferr_q <= 1'b0;
      priv_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (i_start) begin
            coprocessor_id_field_q <= i_opword[COPROCESSOR_ID_FIELD_HI:COPROCESSOR_ID_FIELD_LO];
            eamode_q <= i_opword[EAMODE_HI:EAMODE_LO];
            ea_q <= i_ea;
            save_q <= i_is_save;
            if (i_is_save && !i_supervisor) begin
              priv_q <= 1'b1;
            end else if (i_is_save) begin
              ir_req_q <= 1'b1;
              ir_we_q <= 1'b0;
              ir_sel_q <= IR_SEL_SAVE;
              state_q <= ST_SV_RD;
            end else begin
              mem_req_q <= 1'b1;
              mem_we_q <= 1'b0;
              mem_addr_q <= i_ea;
              state_q <= ST_RS_MRD;
            end
          end
        end
        ST_SV_RD: begin
          if (i_ir_ack) begin
            ir_req_q <= 1'b0;
            fmt_q <= ir_fw;
            case (fmt_class(ir_fw))
              FC_NOTRDY: begin
                int_req_q <= 1'b1;
                state_q <= ST_SV_INT;
              end
              FC_INVALID: begin
                // a busy coprocessor may refuse here
                ir_req_q <= 1'b1;
                ir_we_q <= 1'b1;
                ir_sel_q <= IR_SEL_CONTROL;
                ir_wdata_q <= DATA_W'(CTRL_ABORT_MASK);
                state_q <= ST_ABORT;
              end
              FC_VALID: begin
                if (!len_ok(ir_fw)) begin
                  ir_req_q <= 1'b1;
                  ir_we_q <= 1'b1;
                  ir_sel_q <= IR_SEL_CONTROL;
                  ir_wdata_q <= DATA_W'(CTRL_ABORT_MASK);
                  state_q <= ST_ABORT;
                end else begin
                  mem_req_q <= 1'b1;
                  mem_we_q <= 1'b1;
                  mem_addr_q <= ea_q;
                  mem_wdata_q <= {ir_fw, FILLER_WORD};
                  state_q <= ST_SV_FMT;
                end
              end
              default: begin
                mem_req_q <= 1'b1;
                mem_we_q <= 1'b1;
                mem_addr_q <= ea_q;
                mem_wdata_q <= {ir_fw, FILLER_WORD};
                state_q <= ST_SV_FMT;
              end
            endcase
          end
        end
        ST_SV_INT: begin
          if (i_int_svc_done) begin
            int_req_q <= 1'b0;
            ir_req_q <= 1'b1;
            ir_we_q <= 1'b0;
            ir_sel_q <= IR_SEL_SAVE;
            state_q <= ST_SV_RD;
          end
        end
        ST_SV_FMT: begin
          if (i_mem_ack) begin
            mem_req_q <= 1'b0;
            if (fmt_class(fmt_q) != FC_VALID ||
                len_words(fmt_q) == CNT_ZERO) begin
              done_q <= 1'b1;
              state_q <= ST_IDLE;
            end else begin
              src_left_q <= len_words(fmt_q);
              snk_left_q <= len_words(fmt_q);
              xaddr_q <= ea_q + ADDR_W'({fmt_q[FMT_LEN_HI:FMT_LEN_LO],
                                        2'b00});
              state_q <= ST_XFER;
            end
          end
        end
        ST_RS_MRD: begin
          if (i_mem_ack) begin
            mem_req_q <= 1'b0;
            fmt_q <= mem_fw;
            if (fmt_class(mem_fw) == FC_VALID && !len_ok(mem_fw)) begin
              ir_req_q <= 1'b1;
              ir_we_q <= 1'b1;
              ir_sel_q <= IR_SEL_CONTROL;
              ir_wdata_q <= DATA_W'(CTRL_ABORT_MASK);
              state_q <= ST_ABORT;
            end else begin
              ir_req_q <= 1'b1;
              ir_we_q <= 1'b1;
              ir_sel_q <= IR_SEL_RESTORE;
              ir_wdata_q <= DATA_W'(mem_fw);
              state_q <= ST_RS_WR;
            end
          end
        end
        ST_RS_WR: begin
          if (i_ir_ack) begin
            ir_we_q <= 1'b0;
            state_q <= ST_RS_RD;
          end
        end
        ST_RS_RD: begin
          if (i_ir_ack) begin
            case (fmt_class(ir_fw))
              FC_NOTRDY: begin
                // request stays up: immediate reread, no interrupt window
                ir_req_q <= 1'b1;
              end
              FC_EMPTY: begin
                ir_req_q <= 1'b0;
                done_q <= 1'b1;
                state_q <= ST_IDLE;
              end
              FC_INVALID: begin
                ir_we_q <= 1'b1;
                ir_sel_q <= IR_SEL_CONTROL;
                ir_wdata_q <= DATA_W'(CTRL_ABORT_MASK);
                state_q <= ST_ABORT;
              end
              default: begin
                ir_req_q <= 1'b0;
                if (len_words(fmt_q) == CNT_ZERO) begin
                  done_q <= 1'b1;
                  state_q <= ST_IDLE;
                end else begin
                  src_left_q <= len_words(fmt_q);
                  snk_left_q <= len_words(fmt_q);
                  xaddr_q <= ea_q + MEM_STEP;
                  state_q <= ST_XFER;
                end
              end
            endcase
          end
        end
        ST_XFER: begin
          if (snk_left_q == CNT_ZERO) begin
            done_q <= 1'b1;
            state_q <= ST_IDLE;
          end else if (save_q) begin
            if (ir_req_q) begin
              if (i_ir_ack) begin
                ir_req_q <= 1'b0;
                src_left_q <= src_left_q - CNT_ONE;
              end
            end else if (src_left_q != CNT_ZERO && f_in_ready) begin
              ir_req_q <= 1'b1;
              ir_we_q <= 1'b0;
              ir_sel_q <= IR_SEL_OPERAND;
            end
            if (mem_req_q) begin
              if (i_mem_ack) begin
                mem_req_q <= 1'b0;
                snk_left_q <= snk_left_q - CNT_ONE;
                xaddr_q <= xaddr_q - MEM_STEP;
              end
            end else if (f_out_valid) begin
              mem_req_q <= 1'b1;
              mem_we_q <= 1'b1;
              mem_addr_q <= xaddr_q;
              mem_wdata_q <= f_out_data;
            end
          end else begin
            if (mem_req_q) begin
              if (i_mem_ack) begin
                mem_req_q <= 1'b0;
                src_left_q <= src_left_q - CNT_ONE;
                xaddr_q <= xaddr_q + MEM_STEP;
              end
            end else if (src_left_q != CNT_ZERO && f_in_ready) begin
              mem_req_q <= 1'b1;
              mem_we_q <= 1'b0;
              mem_addr_q <= xaddr_q;
            end
            if (ir_req_q) begin
              if (i_ir_ack) begin
                ir_req_q <= 1'b0;
                snk_left_q <= snk_left_q - CNT_ONE;
              end
            end else if (f_out_valid) begin
              ir_req_q <= 1'b1;
              ir_we_q <= 1'b1;
              ir_sel_q <= IR_SEL_OPERAND;
              ir_wdata_q <= f_out_data;
            end
          end
        end
        ST_ABORT: begin
          if (i_ir_ack) begin
            ir_req_q <= 1'b0;
            ferr_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  a_priv_no_access: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    state_q == ST_IDLE && i_start && i_is_save && !i_supervisor
    |=> priv_q && !ir_req_q ##1 !ir_req_q && state_q == ST_IDLE)
    else $error("user-level save touched the interface registers");
  a_coprocessor_id_field_field: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    state_q == ST_IDLE && i_start
    |=> coprocessor_id_field_q == $past(i_opword[11:9]) && eamode_q == $past(i_opword[5:0]))
    else $error("coprocessor id or mode not taken from opword");
  a_save_notrdy_int: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    state_q == ST_SV_RD && i_ir_ack && ir_fw[15:8] == CODE_NOTRDY
    |=> int_req_q && !ir_req_q)
    else $error("save not-ready did not request interrupt service");
  a_rst_reread: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    state_q == ST_RS_RD && i_ir_ack && ir_fw[15:8] == CODE_NOTRDY
    |=> ir_req_q && !ir_we_q && ir_sel_q == IR_SEL_RESTORE && !int_req_q)
    else $error("restore not-ready was not reread at once");
  a_reserved_abort: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    state_q == ST_SV_RD && i_ir_ack && ir_fw[15:8] > CODE_NOTRDY &&
    ir_fw[15:8] < CODE_VALID_MIN
    |=> ir_req_q && ir_we_q && ir_sel_q == IR_SEL_CONTROL &&
        ir_wdata_q[15:0] == CTRL_ABORT_MASK)
    else $error("invalid or reserved save code did not abort");
  a_rst_invalid: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    state_q == ST_RS_RD && i_ir_ack && ir_fw[15:8] == CODE_INVALID
    |=> ir_sel_q == IR_SEL_CONTROL && ir_we_q
    ##[1:20] ferr_q)
    else $error("restore invalid did not abort and raise format error");
  a_len_abort: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    state_q == ST_SV_RD && i_ir_ack && ir_fw[15:8] >= CODE_VALID_MIN &&
    ir_fw[1:0] != 2'h0
    |=> ir_sel_q == IR_SEL_CONTROL && !mem_req_q)
    else $error("misaligned length was not refused");
  a_empty_fmt: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    state_q == ST_SV_RD && i_ir_ack && ir_fw[15:8] == CODE_EMPTY
    |=> mem_req_q && mem_we_q && mem_addr_q == ea_q &&
        mem_wdata_q == {$past(ir_fw), FILLER_WORD})
    else $error("empty format word not stored at the effective address");
  a_first_data_addr: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    state_q == ST_SV_FMT && i_mem_ack && fmt_q[15:8] >= CODE_VALID_MIN &&
    fmt_q[7:2] != 6'h00
    |=> xaddr_q == ea_q + {fmt_q[7:0], 2'b00})
    else $error("save data does not start at ea plus length times four");
  a_restore_start: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    state_q == ST_IDLE && i_start && !i_is_save
    |=> mem_req_q && !mem_we_q && mem_addr_q == $past(i_ea))
    else $error("restore did not fetch the format word first");
  a_empty_done: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    state_q == ST_RS_RD && i_ir_ack && ir_fw[15:8] == CODE_EMPTY
    |=> done_q && !ir_req_q)
    else $error("restore of empty frame did not finish");

endmodule
`default_nettype wire

// File: ccsr_copro_model.sv
// coprocessor model answering the interface register port
`timescale 1ns/1ps
`default_nettype none
module ccsr_copro_model
  import ccsr_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // scenario control
  input wire logic i_load,
  input wire logic [1:0] i_nrdy,
  input wire logic i_slow,
  input wire logic [15:0] i_save_fmt,
  // interface register port
  input wire logic i_ir_req,
  input wire logic i_ir_we,
  input wire logic [2:0] i_ir_sel,
  input wire logic [2:0] i_ir_coprocessor_id_field,
  input wire logic [DATA_W-1:0] i_ir_wdata,
  output logic o_ir_ack,
  output logic [DATA_W-1:0] o_ir_rdata
);
  logic [1:0] nr_q;
  logic [15:0] rst_q;
  logic [2:0] coprocessor_id_field;
  logic inv;
  logic go;
  logic [31:0] rd;
  logic [31:0] opq [$];
  int acc;
  int aborts;
  int op_n;

  always @(posedge i_ref_clk) begin
    // one decision per edge, so ack and data are each driven once
    go = i_resetn && i_ir_req && !o_ir_ack && !(i_slow && $urandom % 2);
    // released data must not keep showing the last answer
    rd = ~o_ir_rdata;
    if (!i_resetn) begin
      nr_q <= 2'h0;
      acc = 0;
      aborts = 0;
    end else begin
      if (i_load) begin
        nr_q <= i_nrdy;
        op_n = 0;
      end
      if (go) begin
        acc++;
        coprocessor_id_field <= i_ir_coprocessor_id_field;
        if (i_ir_we) begin
          if (i_ir_sel == IR_SEL_RESTORE) rst_q <= i_ir_wdata[15:0];
          if (i_ir_sel == IR_SEL_OPERAND) opq.push_back(i_ir_wdata);
          if (i_ir_sel == IR_SEL_CONTROL) aborts++;
        end else if (nr_q != 2'h0 && i_ir_sel != IR_SEL_OPERAND) begin
          nr_q <= nr_q - 2'h1;
          rd = {16'h0, CODE_NOTRDY, 8'h0};
        end else if (i_ir_sel == IR_SEL_SAVE) begin
          rd = {16'h0, i_save_fmt};
        end else if (i_ir_sel == IR_SEL_RESTORE) begin
          inv = rst_q[15:8] > CODE_NOTRDY && rst_q[15:8] < CODE_VALID_MIN;
          rd = {16'h0, inv ? {CODE_INVALID, 8'h0} : rst_q};
        end else begin
          rd = 32'ha500_0000 + op_n;
          op_n++;
        end
      end
    end
    o_ir_ack <= go;
    o_ir_rdata <= rd;
  end
endmodule
`default_nettype wire

// File: test_coproc_context_save_restore.sv
// self-checking bench for the context save/restore sequencer
`timescale 1ns/1ps
`default_nettype none
module test_coproc_context_save_restore;
  import ccsr_pkg::*;
  logic clk, rstn, start, is_save, sup, svc_done, ir_ack, mem_ack, slow;
  logic busy, done, ferr, priv, svc, ir_req, ir_we, mem_req, mem_we;
  logic [15:0] op, lastf, sfmt, f;
  logic [2:0] mhi, mreg, sel, coprocessor_id_field;
  logic [1:0] nrdy;
  logic [31:0] ea, irw, irr, maddr, mw, mr;
  logic [31:0] mem [logic [31:0]];
  logic [63:0] wq [$];
  logic [15:0] fl [10] = '{16'h0044, 16'h0200, 16'h0500, 16'h0f08,
    16'h1008, 16'h100a, 16'hff04, 16'h1000, 16'h20fc, 16'h4007};
  int fail_count, total_checks, svc_n;

  ccsr_ctx #(.DEPTH(FIFO_DEPTH)) dut_u (.i_ref_clk(clk), .i_resetn(rstn),
    .i_start(start), .i_is_save(is_save), .i_supervisor(sup),
    .i_opword(op), .i_ea(ea), .o_busy(busy), .o_done(done),
    .o_fmt_err(ferr), .o_priv_viol(priv), .o_last_format(lastf),
    .o_ea_mode_hi(mhi), .o_ea_reg(mreg), .o_int_svc_req(svc),
    .i_int_svc_done(svc_done), .o_ir_req(ir_req), .o_ir_we(ir_we),
    .o_ir_sel(sel), .o_ir_coprocessor_id_field(coprocessor_id_field), .o_ir_wdata(irw), .i_ir_ack(ir_ack),
    .i_ir_rdata(irr), .o_mem_req(mem_req), .o_mem_we(mem_we),
    .o_mem_addr(maddr), .o_mem_wdata(mw), .i_mem_ack(mem_ack),
    .i_mem_rdata(mr));

  ccsr_copro_model cp_u (.i_ref_clk(clk), .i_resetn(rstn), .i_load(start),
    .i_nrdy(nrdy), .i_slow(slow), .i_save_fmt(sfmt), .i_ir_req(ir_req),
    .i_ir_we(ir_we), .i_ir_sel(sel), .i_ir_coprocessor_id_field(coprocessor_id_field), .i_ir_wdata(irw),
    .o_ir_ack(ir_ack), .o_ir_rdata(irr));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // memory and interrupt service side
  always @(posedge clk) begin
    mem_ack <= mem_req && !mem_ack;
    svc_done <= svc && !svc_done;
    if (svc && !svc_done) svc_n++;
    if (mem_req && !mem_ack && mem_we) wq.push_back({maddr, mw});
    if (mem_req && !mem_ack && !mem_we) begin
      mr <= mem.exists(maddr) ? mem[maddr] : 32'hdead_beef;
    end else begin
      mr <= ~mr;
    end
  end

  task automatic check(string nm, logic [63:0] seen, logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic run(bit sv, bit s, logic [15:0] fw, int nr);
    int n, acc0, ab0, nw;
    logic [1:0] kind, got;
    logic [31:0] e;
    logic [15:0] o;
    logic [7:0] c;
    logic [31:0] d [$];
    c = fw[15:8];
    n = fw[7:0] / 4;
    kind = (sv && !s) ? 2'h2 : (c == 8'h0) ? 2'h0 :
      (c < 8'h10 || fw[1:0] != 2'h0) ? 2'h1 : 2'h0;
    e = $urandom & 32'h00ff_fff0;
    o = $urandom;
    mem[e] = {fw, FILLER_WORD};
    for (int k = 0; k < n; k++) begin
      d.push_back($urandom);
      mem[e + 4 + 4 * k] = d[k];
    end
    @(posedge clk);
    wq.delete();
    cp_u.opq.delete();
    svc_n = 0;
    acc0 = cp_u.acc;
    ab0 = cp_u.aborts;
    start <= 1'b1;
    is_save <= sv;
    sup <= s;
    sfmt <= fw;
    nrdy <= 2'(nr);
    ea <= e;
    op <= o;
    slow <= $urandom % 2;
    @(posedge clk);
    start <= 1'b0;
    got = 2'h3;
    #1;
    check("busy", busy, kind != 2'h2);
    for (int t = 0; t < 3000; t++) begin
      #1;
      if (done || ferr || priv) begin
        got = priv ? 2'h2 : ferr ? 2'h1 : 2'h0;
        break;
      end
      @(posedge clk);
    end
    check("result", got, kind);
    check("idle", busy, 1'b0);
    check("aborts", cp_u.aborts - ab0, kind == 2'h1);
    check("svc", svc_n, (sv && kind != 2'h2) ? nr : 0);
    check("mode", {mhi, mreg}, o[5:0]);
    if (kind == 2'h2) check("access", cp_u.acc - acc0, 0);
    else check("coprocessor_id_field", cp_u.coprocessor_id_field, o[11:9]);
    nw = (sv && kind == 2'h0) ? ((c == 8'h0) ? 1 : n + 1) : 0;
    check("nwrites", wq.size(), nw);
    if (nw > 0) begin
      check("fmtword", wq[0], {e, fw, FILLER_WORD});
      check("lastfmt", lastf, fw);
    end
    for (int k = 1; k < nw; k++) begin
      check("savedata", wq[k], {e + fw[7:0] * 4 - 4 * (k - 1),
        32'ha500_0000 + k - 1});
    end
    nw = (!sv && kind == 2'h0 && c != 8'h0) ? n : 0;
    if (!sv) check("nops", cp_u.opq.size(), nw);
    for (int k = 0; k < nw; k++) check("opdata", cp_u.opq[k], d[k]);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    {rstn, start, is_save, sup, slow, nrdy, svc_done, mem_ack} = '0;
    {op, sfmt, ea, mr} = '0;
    void'($urandom(36625));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    foreach (fl[i]) begin
      run(1'b1, 1'b1, fl[i], i % 3);
      run(1'b0, 1'b1, fl[i], i % 2);
    end
    $display("test fixed format codes finished");
    run(1'b1, 1'b0, 16'h1008, 1);
    $display("test user level save finished");
    repeat (12) begin
      f = {8'h10 + 8'($urandom % 240), 6'($urandom), 2'b00};
      run(1'b1, 1'b1, f, $urandom % 3);
      run(1'b0, 1'b1, f, $urandom % 2);
    end
    $display("test random frames finished");
    give_verdict();
  end

  // cut a hang short well past the expected run length
  initial begin
    #5_000_000;
    fail_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
